// File: design/scw_pkg.sv
// Package: register map, field layout and reset values of the system config bank
package scw_pkg;

  // Register byte addresses (no offsets are printed, so these are chosen)
  localparam logic [7:0] ADDR_OPTIONS = 8'h00;
  localparam logic [7:0] ADDR_CLKOUT  = 8'h04;
  localparam logic [7:0] ADDR_ID_HIGH = 8'h08;
  localparam logic [7:0] ADDR_ID_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_WAKEUP  = 8'h10;

  // System options fields
  localparam int OPT_WDOG_EN_BIT   = 7;
  localparam int OPT_WDOG_LONG_BIT = 6;
  localparam int OPT_STOP_EN_BIT   = 5;
  localparam logic OPT_WDOG_EN_RST   = 1'b1;
  localparam logic OPT_WDOG_LONG_RST = 1'b1;
  localparam logic OPT_STOP_EN_RST   = 1'b0;

  // Clock output control fields
  localparam int CLK_PIN_EN_BIT = 4;
  localparam int CLK_DIV_LSB    = 0;
  localparam int CLK_DIV_W      = 3;

  // Periodic wakeup control fields
  localparam int WK_FLAG_BIT   = 7;
  localparam int WK_ACK_BIT    = 6;
  localparam int WK_CLKSEL_BIT = 5;
  localparam int WK_IEN_BIT    = 4;
  localparam int WK_DLY_LSB    = 0;
  localparam int WK_DLY_W      = 3;

  // Internal wakeup oscillator nominal rate
  localparam int WK_OSC_HZ = 1000;

  // Part id: value is arbitrary, not any real part code
  localparam logic [11:0] PART_ID_DEFAULT = 12'h5a3;

  // Reserved id-high bits read as this (indeterminate in the hardware)
  localparam logic [3:0] ID_HIGH_RSVD = 4'h0;

endpackage

// File: design/scw_sysconfig.sv
// System configuration bank: options, clock output, part id, periodic wakeup
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps

module scw_sysconfig #(
  parameter logic [11:0] PART_ID = scw_pkg::PART_ID_DEFAULT
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Wakeup clock sources, asynchronous to i_mclk
  input  wire logic        i_wake_osc,
  input  wire logic        i_wake_ext,
  // Core hooks
  input  wire logic        i_stop_attempt,
  output logic             o_watchdog_enable,
  output logic             o_watchdog_long_timeout,
  output logic             o_stop_mode_enable,
  output logic             o_illegal_stop_reset,
  output logic             o_wakeup_irq,
  // Clock output port pin
  output logic             o_clkout,
  output logic             o_clkout_oe_n
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    logic        opt_written;
    logic        wdog_en;
    logic        wdog_long;
    logic        stop_en;
    logic        pin_en;
    logic [2:0]  clk_div;
    logic [2:0]  div_cnt;
    logic        clk_lvl;
    logic        clkout;
    logic        clkout_oe_n;
    logic        illegal_stop;
    logic        wk_flag;
    logic        wk_clksel;
    logic        wk_ien;
    logic [2:0]  wk_dly;
    logic [2:0]  osc_sync;
    logic [2:0]  ext_sync;
    logic        osc_lvl;
    logic        ext_lvl;
    logic [14:0] wk_cnt;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } scw_state_t;

  scw_state_t st;
  scw_state_t next_st;
  // Kept apart from st: it has its own reset and its own process
  logic [1:0] rst_sync;
  logic       rstn_int;

  assign rstn_int = rst_sync[1];

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  // Terminal count in source ticks; internal ticks are 1 ms each
  function automatic logic [14:0] scw_wake_limit(input logic [2:0] dly,
                                                 input logic       ext);
    logic [14:0] lim;
    lim = 15'h0000;
    if (ext) begin
      case (dly)
        3'h1:    lim = 15'h00ff;  // /256
        3'h2:    lim = 15'h03ff;  // /1024
        3'h3:    lim = 15'h07ff;
        3'h4:    lim = 15'h0fff;
        3'h5:    lim = 15'h1fff;
        3'h6:    lim = 15'h3fff;
        3'h7:    lim = 15'h7fff;  // /32768
        default: lim = 15'h0000;
      endcase
    end else begin
      case (dly)
        3'h1:    lim = 15'h0007;  // 8 ms
        3'h2:    lim = 15'h001f;  // 32 ms
        3'h3:    lim = 15'h003f;
        3'h4:    lim = 15'h007f;
        3'h5:    lim = 15'h00ff;
        3'h6:    lim = 15'h01ff;
        3'h7:    lim = 15'h03ff;  // 1024 ms
        default: lim = 15'h0000;
      endcase
    end
    return lim;
  endfunction

  //--------------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------------
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;
  logic        tick;
  logic        timeout;
  logic [7:0]  wb;
  logic [7:0]  rb;

  always_comb begin
    next_st = st;
    wb      = i_pwdata[7:0];
    rb      = 8'h00;

    // Address decode over the low word-aligned map
    addr_ok = (i_paddr == scw_pkg::ADDR_OPTIONS) ||
              (i_paddr == scw_pkg::ADDR_CLKOUT)  ||
              (i_paddr == scw_pkg::ADDR_ID_HIGH) ||
              (i_paddr == scw_pkg::ADDR_ID_LOW)  ||
              (i_paddr == scw_pkg::ADDR_WAKEUP);
    // One-wait slave: pready is registered, so the access phase completes in its second cycle
    wr_acc = i_psel && i_penable && i_pwrite && !st.pready && i_pstrb[0];
    rd_acc = i_psel && i_penable && !i_pwrite && !st.pready;

    next_st.pready  = i_psel && i_penable && !st.pready;
    next_st.pslverr = i_psel && i_penable && !st.pready && !addr_ok;

    // Readback mux
    case (i_paddr)
      scw_pkg::ADDR_OPTIONS: begin
        rb[scw_pkg::OPT_WDOG_EN_BIT]   = st.wdog_en;
        rb[scw_pkg::OPT_WDOG_LONG_BIT] = st.wdog_long;
        rb[scw_pkg::OPT_STOP_EN_BIT]   = st.stop_en;  // 3:2 stay zero
      end
      scw_pkg::ADDR_CLKOUT: begin
        rb[scw_pkg::CLK_PIN_EN_BIT] = st.pin_en;
        rb[2:0]                     = st.clk_div;
      end
      scw_pkg::ADDR_ID_HIGH: rb = {scw_pkg::ID_HIGH_RSVD,
                                   PART_ID[11:8]};
      scw_pkg::ADDR_ID_LOW:  rb = PART_ID[7:0];
      scw_pkg::ADDR_WAKEUP: begin
        rb[scw_pkg::WK_FLAG_BIT]   = st.wk_flag;
        rb[scw_pkg::WK_CLKSEL_BIT] = st.wk_clksel;
        rb[scw_pkg::WK_IEN_BIT]    = st.wk_ien;
        rb[2:0]                    = st.wk_dly;  // ack and 3 read zero
      end
      default: rb = 8'h00;
    endcase
    next_st.prdata = rd_acc ? {24'h000000, rb} : 32'h00000000;

    // Write-once options: later writes dropped silently
    if (wr_acc && i_paddr == scw_pkg::ADDR_OPTIONS && !st.opt_written) begin
      next_st.opt_written = 1'b1;
      next_st.wdog_en     = wb[scw_pkg::OPT_WDOG_EN_BIT];
      next_st.wdog_long   = wb[scw_pkg::OPT_WDOG_LONG_BIT];
      next_st.stop_en     = wb[scw_pkg::OPT_STOP_EN_BIT];
    end
    if (wr_acc && i_paddr == scw_pkg::ADDR_CLKOUT) begin
      next_st.pin_en  = wb[scw_pkg::CLK_PIN_EN_BIT];
      next_st.clk_div = wb[2:0];
    end

    // Stop with stop mode disabled requests an illegal-opcode reset
    next_st.illegal_stop = i_stop_attempt && !st.stop_en;

    // Clock output divider: half period is clk_div bus clocks
    if (st.clk_div == 3'h0) begin
      next_st.div_cnt = 3'h0;
      next_st.clk_lvl = 1'b0;
    end else if (st.div_cnt >= st.clk_div - 3'h1) begin
      next_st.div_cnt = 3'h0;
      next_st.clk_lvl = !st.clk_lvl;
    end else begin
      next_st.div_cnt = st.div_cnt + 3'h1;
    end
    next_st.clkout      = st.pin_en && st.clk_lvl;
    next_st.clkout_oe_n = !st.pin_en;

    // Wakeup source synchronisers; second and third must agree
    next_st.osc_sync = {st.osc_sync[1:0], i_wake_osc};
    next_st.ext_sync = {st.ext_sync[1:0], i_wake_ext};
    if (st.osc_sync[2] == st.osc_sync[1]) begin
      next_st.osc_lvl = st.osc_sync[2];
    end
    if (st.ext_sync[2] == st.ext_sync[1]) begin
      next_st.ext_lvl = st.ext_sync[2];
    end
    // Rising edge of the selected source is one timer tick; the
    // oscillator is a free-running input, untouched by bus clocking
    tick = st.wk_clksel ? (next_st.ext_lvl && !st.ext_lvl)
                        : (next_st.osc_lvl && !st.osc_lvl);
    timeout = 1'b0;
    if (st.wk_dly == 3'h0) begin
      next_st.wk_cnt = 15'h0000;
    end else if (tick) begin
      if (st.wk_cnt >= scw_wake_limit(st.wk_dly, st.wk_clksel)) begin
        next_st.wk_cnt = 15'h0000;
        timeout        = 1'b1;
      end else begin
        next_st.wk_cnt = st.wk_cnt + 15'h0001;
      end
    end

    if (wr_acc && i_paddr == scw_pkg::ADDR_WAKEUP) begin
      next_st.wk_clksel = wb[scw_pkg::WK_CLKSEL_BIT];
      next_st.wk_ien    = wb[scw_pkg::WK_IEN_BIT];
      next_st.wk_dly    = wb[2:0];
      if (wb[scw_pkg::WK_ACK_BIT]) begin
        next_st.wk_flag = 1'b0;
      end
    end
    // Timeout set beats a same-cycle acknowledge
    if (timeout) begin
      next_st.wk_flag = 1'b1;
    end
    next_st.irq = next_st.wk_flag && next_st.wk_ien;
  end

  //--------------------------------------------------------------------
  // Reset release synchroniser
  //--------------------------------------------------------------------
  // Async assert, release through two flops
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------
  // Everything but the reset synchroniser resets on the released copy
  always_ff @(posedge i_mclk or negedge rstn_int) begin
    if (!rstn_int) begin
      st.opt_written  <= 1'b0;
      st.wdog_en      <= scw_pkg::OPT_WDOG_EN_RST;
      st.wdog_long    <= scw_pkg::OPT_WDOG_LONG_RST;
      st.stop_en      <= scw_pkg::OPT_STOP_EN_RST;
      st.pin_en       <= 1'b0;
      st.clk_div      <= 3'h0;
      st.div_cnt      <= 3'h0;
      st.clk_lvl      <= 1'b0;
      st.clkout       <= 1'b0;
      st.clkout_oe_n  <= 1'b1;
      st.illegal_stop <= 1'b0;
      st.wk_flag      <= 1'b0;
      st.wk_clksel    <= 1'b0;
      st.wk_ien       <= 1'b0;
      st.wk_dly       <= 3'h0;
      st.osc_sync     <= 3'h0;
      st.ext_sync     <= 3'h0;
      st.osc_lvl      <= 1'b0;
      st.ext_lvl      <= 1'b0;
      st.wk_cnt       <= 15'h0000;
      st.irq          <= 1'b0;
      st.prdata       <= 32'h00000000;
      st.pready       <= 1'b0;
      st.pslverr      <= 1'b0;
    end else begin
      st.opt_written  <= next_st.opt_written;
      st.wdog_en      <= next_st.wdog_en;
      st.wdog_long    <= next_st.wdog_long;
      st.stop_en      <= next_st.stop_en;
      st.pin_en       <= next_st.pin_en;
      st.clk_div      <= next_st.clk_div;
      st.div_cnt      <= next_st.div_cnt;
      st.clk_lvl      <= next_st.clk_lvl;
      st.clkout       <= next_st.clkout;
      st.clkout_oe_n  <= next_st.clkout_oe_n;
      st.illegal_stop <= next_st.illegal_stop;
      st.wk_flag      <= next_st.wk_flag;
      st.wk_clksel    <= next_st.wk_clksel;
      st.wk_ien       <= next_st.wk_ien;
      st.wk_dly       <= next_st.wk_dly;
      st.osc_sync     <= next_st.osc_sync;
      st.ext_sync     <= next_st.ext_sync;
      st.osc_lvl      <= next_st.osc_lvl;
      st.ext_lvl      <= next_st.ext_lvl;
      st.wk_cnt       <= next_st.wk_cnt;
      st.irq          <= next_st.irq;
      st.prdata       <= next_st.prdata;
      st.pready       <= next_st.pready;
      st.pslverr      <= next_st.pslverr;
    end
  end

  //--------------------------------------------------------------------
  // Outputs, all straight from flops
  //--------------------------------------------------------------------
  assign o_prdata                = st.prdata;
  assign o_pready                = st.pready;
  assign o_pslverr               = st.pslverr;
  assign o_watchdog_enable       = st.wdog_en;
  assign o_watchdog_long_timeout = st.wdog_long;
  assign o_stop_mode_enable      = st.stop_en;
  assign o_illegal_stop_reset    = st.illegal_stop;
  assign o_wakeup_irq            = st.irq;
  assign o_clkout                = st.clkout;
  assign o_clkout_oe_n           = st.clkout_oe_n;

endmodule

// File: testbench/scw_sysconfig_assertions.sv
// Checker: bus timing and control rules of the system config bank
`timescale 1ns/100ps
module scw_sysconfig_assertions (
  // Clock, reset and bus
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Core hooks and pin
  input wire logic        i_stop_attempt,
  input wire logic        o_watchdog_enable,
  input wire logic        o_watchdog_long_timeout,
  input wire logic        o_stop_mode_enable,
  input wire logic        o_illegal_stop_reset,
  input wire logic        o_wakeup_irq,
  input wire logic        o_clkout,
  input wire logic        o_clkout_oe_n
);
  // ----
  // Helpers
  // ----
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  logic       opt_done;
  logic [2:0] opts;
  assign opts = {o_watchdog_enable, o_watchdog_long_timeout,
                 o_stop_mode_enable};
  // Remembers the first completed options write; later ones must not stick
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      opt_done <= 1'b0;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
                 && i_paddr == scw_pkg::ADDR_OPTIONS) begin
      opt_done <= 1'b1;
    end
  end
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable;
  endsequence
  sequence s_ack;
    i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
      && i_paddr == scw_pkg::ADDR_WAKEUP && i_pwdata[6];
  endsequence
  // ----
  // Assertions
  // ----
  AST_READY_ONE_WAIT: assert property (s_setup ##1 s_access |=> o_pready)
    else $error("pready not one cycle after access");
  AST_READY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  AST_OPT_AT_WRITE: assert property ($changed(opts) |-> o_pready && i_pwrite
    && i_paddr == scw_pkg::ADDR_OPTIONS) else $error("options moved alone");
  AST_OPT_ONCE: assert property (opt_done |-> $stable(opts))
    else $error("options changed after first write");
  AST_ILLEGAL_STOP: assert property (1'b1 |=> o_illegal_stop_reset ==
    ($past(i_stop_attempt) && !$past(o_stop_mode_enable)))
    else $error("illegal stop reset wrong");
  AST_PIN_OFF_LOW: assert property (o_clkout_oe_n |-> !o_clkout)
    else $error("clock output high while pin disabled");
  AST_ACK_DROPS_IRQ: assert property (s_ack |-> ##[0:2] !o_wakeup_irq)
    else $error("irq stays after acknowledge");
endmodule

bind scw_sysconfig scw_sysconfig_assertions u_chk (
  .i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_pstrb, .o_pready, .o_pslverr, .i_stop_attempt, .o_watchdog_enable,
  .o_watchdog_long_timeout, .o_stop_mode_enable, .o_illegal_stop_reset,
  .o_wakeup_irq, .o_clkout, .o_clkout_oe_n
);

// File: testbench/scw_sysconfig_bench.sv
// Bench: register, clock-output and wakeup checks of the config bank
`timescale 1ns/100ps
module scw_sysconfig_bench;
  // ----
  // Signals
  // ----
  localparam logic [11:0] ID = 12'h3c6; // Arbitrary part id
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, osc = 1'b0, ext = 1'b0, stp = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, err_o, err, wd_en, wd_lg, st_en, ill, irq, ck, oe_n;
  int          failures = 0, checked = 0, n;
  int          per[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};

  // Bus clock, 25 ns period
  always #12.5 clk = ~clk;

  scw_sysconfig #(.PART_ID(ID)) u_dut (
    .i_mclk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(err_o),
    .i_wake_osc(osc), .i_wake_ext(ext), .i_stop_attempt(stp),
    .o_watchdog_enable(wd_en), .o_watchdog_long_timeout(wd_lg),
    .o_stop_mode_enable(st_en), .o_illegal_stop_reset(ill),
    .o_wakeup_irq(irq), .o_clkout(ck), .o_clkout_oe_n(oe_n)
  );

  // ----
  // Tasks
  // ----
  task stop_test();
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      failures++;
      stop_test();
    end
    rd = prdata;
    err = err_o;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk8(rd[7:0], e, m);
  endtask
  task wk(input logic [7:0] d);
    apb(1'b1, scw_pkg::ADDR_WAKEUP, d);
  endtask
  task stop_chk(input logic e);
    stp <= 1'b1;
    @(posedge clk);
    stp <= 1'b0;
    @(posedge clk);
    chk1(ill, e);
  endtask
  // Ticks on one wakeup source, slow enough for the three-flop sync
  task tick(input logic e, input int cnt);
    repeat (cnt) begin
      osc <= !e;
      ext <= e;
      repeat (4) @(posedge clk);
      osc <= 1'b0;
      ext <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // Cycles the clock output stays high; the first call may see a part
  task half();
    int k;
    k = 0;
    while (ck !== 1'b1 && k < 64) begin
      @(posedge clk);
      k++;
    end
    n = 0;
    while (ck === 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(scw_pkg::ADDR_OPTIONS, 8'hc0, 8'hec);
    stop_chk(1'b1);
    apb(1'b1, scw_pkg::ADDR_OPTIONS, 8'h2c);
    rdc(scw_pkg::ADDR_OPTIONS, 8'h20, 8'hec);
    chk8({5'h00, wd_en, wd_lg, st_en}, 8'h01, 8'h07);
    stop_chk(1'b0);
    apb(1'b1, scw_pkg::ADDR_OPTIONS, 8'hc0);
    rdc(scw_pkg::ADDR_OPTIONS, 8'h20, 8'hec);
    // Id is fixed and ignores writes
    apb(1'b1, scw_pkg::ADDR_ID_LOW, ~ID[7:0]);
    apb(1'b1, scw_pkg::ADDR_ID_HIGH, 8'hff);
    rdc(scw_pkg::ADDR_ID_HIGH, {4'h0, ID[11:8]}, 8'h0f);
    rdc(scw_pkg::ADDR_ID_LOW, ID[7:0], 8'hff);
    apb(1'b0, 8'h14, 8'h00);
    chk1(err, 1'b1);
    // Every nonzero divide code, high time equals the code in bus clocks
    for (int d = 1; d < 8; d++) begin
      apb(1'b1, scw_pkg::ADDR_CLKOUT, 8'h10 | 8'(d));
      chk1(oe_n, 1'b0);
      half();
      half();
      chk8(8'(n), 8'(d), 8'hff);
    end
    pstrb <= 4'h0;
    apb(1'b1, scw_pkg::ADDR_CLKOUT, 8'h00);
    pstrb <= 4'hf;
    chk1(oe_n, 1'b0);
    apb(1'b1, scw_pkg::ADDR_CLKOUT, 8'h10);
    repeat (20) begin
      @(posedge clk);
      chk1(ck, 1'b0);
    end
    chk1(oe_n, 1'b0);
    apb(1'b1, scw_pkg::ADDR_CLKOUT, 8'h00);
    chk1(oe_n, 1'b1);
    // Wakeup timer: off, then each internal period to the tick
    tick(1'b0, 20);
    rdc(scw_pkg::ADDR_WAKEUP, 8'h00, 8'hff);
    for (int d = 1; d < 8; d++) begin
      wk(8'h40);
      wk(8'h10 | 8'(d));
      tick(1'b0, per[d] - 1);
      rdc(scw_pkg::ADDR_WAKEUP, 8'h10 | 8'(d), 8'hff);
      tick(1'b0, 1);
      rdc(scw_pkg::ADDR_WAKEUP, 8'h90 | 8'(d), 8'hff);
      chk1(irq, 1'b1);
    end
    wk(8'h97);
    rdc(scw_pkg::ADDR_WAKEUP, 8'h97, 8'hff);
    wk(8'h57);
    rdc(scw_pkg::ADDR_WAKEUP, 8'h17, 8'hff);
    chk1(irq, 1'b0);
    wk(8'h01);
    tick(1'b0, 8);
    rdc(scw_pkg::ADDR_WAKEUP, 8'h81, 8'hff);
    chk1(irq, 1'b0);
    // External source; internal ticks must not count
    wk(8'h71);
    tick(1'b1, 255);
    tick(1'b0, 9);
    rdc(scw_pkg::ADDR_WAKEUP, 8'h31, 8'hff);
    tick(1'b1, 1);
    rdc(scw_pkg::ADDR_WAKEUP, 8'hb1, 8'hff);
    chk1(irq, 1'b1);
    stop_test();
  end
endmodule
